/* File: rtl/mci_interp.v */
// binary command frame interpreter for one stepper axis
//
// Notes on behaviour
// R1: move instruction code 4; type 0 absolute, 1 relative, 2 stored coordinate.
// R2: move operand is a full-range 32-bit signed two's-complement position.
// R3: relative target is actual position plus signed offset; host keeps sum in range.
// R4: target arithmetic wraps at 32 bits; long distances run the short way round.
// R5: a move selects position mode and writes the target into parameter 0.
// R6: move replies right after decoding; further commands accepted during motion.
// R7: moves use the ramp and maximum speed currently held in axis parameters.
// R8: a later stop or rotate command pre-empts a running positioning move.
// R9: host loads a coordinate slot before moving to it.
// R10: accepted move, set, stop reply with status 100, value don't-care.
// R11: set parameter is code 5, writes value to parameter numbered by type.
// R12: parameter 4 holds the maximum positioning speed.
// R13: get from stored program also copies read value into the accumulator.
// R14: get in direct mode replies with value only, accumulator untouched.
// R15: nine-byte frame: address, instruction, type, motor, value msb first, checksum.
// R16: stop is code 3 with type and value zero, motor selects axis; here the motor byte is discarded and every frame drives this one axis.
// R17: stop selects velocity mode and clears target velocity parameter 2.
// R18: get parameter is code 6; direct reply carries OK and the value.
// R19: checksum is the 8-bit sum of the first eight bytes; mismatch rejected.
`timescale 1ns/100ps
`include "mci_map.vh"
module mci_interp
(
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [7:0]  rx_byte,
  input  wire        rx_valid,
  input  wire        cmd_standalone,
  input  wire [31:0] actual_pos,
  input  wire [31:0] stored_point_target_type_rd_data,
  output reg         rx_ready,
  output reg         reply_valid,
  output reg  [7:0]  reply_addr,
  output reg  [7:0]  reply_status,
  output reg  [7:0]  reply_instr,
  output reg  [31:0] reply_value,
  output reg  [31:0] accu,
  output reg  [7:0]  stored_point_target_type_rd_idx,
  output reg         pos_mode,
  output reg  [31:0] target_pos,
  output reg  [31:0] target_vel,
  output reg  [31:0] max_pos_speed,
  output reg         move_start,
  output reg         vel_update
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] S_RECV  = 4'b0001;
  localparam [3:0] S_EXEC  = 4'b0010;
  localparam [3:0] S_READ  = 4'b0100;
  localparam [3:0] S_REPLY = 4'b1000;

  reg  [3:0]  state;
  reg  [3:0]  byte_idx;
  reg  [7:0]  csum;
  reg  [7:0]  frm_addr;
  reg  [7:0]  frm_instr;
  reg  [7:0]  frm_type;
  reg  [31:0] frm_value;
  reg         frm_csum_ok;
  reg         frm_standalone;
  reg         pw_en;
  reg  [7:0]  pw_addr;
  reg  [31:0] pw_data;
  wire [31:0] param_rd;
  wire        take;

  assign take = rx_valid & rx_ready;

  // ----------------------------------------------------------------
  // axis parameter store
  // ----------------------------------------------------------------
  mci_param_mem u_params
  (
    .mclk    (mclk),
    .wr_en   (pw_en),
    .wr_addr (pw_addr),
    .wr_data (pw_data),
    .rd_addr (frm_type),
    .rd_data (param_rd)
  );

  // ----------------------------------------------------------------
  // frame intake and command execution
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state          <= S_RECV;
      byte_idx       <= 4'h0;
      csum           <= `MCI_RST_BYTE;
      frm_addr       <= `MCI_RST_BYTE;
      frm_instr      <= `MCI_RST_BYTE;
      frm_type       <= `MCI_RST_BYTE;
      frm_value      <= `MCI_RST_WORD;
      frm_csum_ok    <= 1'b0;
      frm_standalone <= 1'b0;
      pw_en          <= 1'b0;
      pw_addr        <= `MCI_RST_BYTE;
      pw_data        <= `MCI_RST_WORD;
      rx_ready       <= 1'b1;
      reply_valid    <= 1'b0;
      reply_addr     <= `MCI_RST_BYTE;
      reply_status   <= `MCI_RST_BYTE;
      reply_instr    <= `MCI_RST_BYTE;
      reply_value    <= `MCI_RST_WORD;
      accu           <= `MCI_RST_WORD;
      stored_point_target_type_rd_idx   <= `MCI_RST_BYTE;
      pos_mode       <= 1'b0;
      target_pos     <= `MCI_RST_WORD;
      target_vel     <= `MCI_RST_WORD;
      max_pos_speed  <= `MCI_RST_WORD;
      move_start     <= 1'b0;
      vel_update     <= 1'b0;
    end
    else
    begin
      pw_en       <= 1'b0;
      reply_valid <= 1'b0;
      move_start  <= 1'b0;
      vel_update  <= 1'b0;
      case (state)
        S_RECV:
        begin
          if (take)
          begin
            // fields arrive in fixed order, value msb first [R15]
            case (byte_idx)
              `MCI_IDX_ADDR:
              begin
                frm_addr       <= rx_byte;
                frm_standalone <= cmd_standalone;
              end
              `MCI_IDX_INSTR: frm_instr <= rx_byte;
              `MCI_IDX_TYPE:  frm_type  <= rx_byte;
              `MCI_IDX_MOTOR: frm_value <= `MCI_RST_WORD;
              `MCI_IDX_CSUM:  frm_csum_ok <= (rx_byte == csum); // [R19]
              default:        frm_value <= {frm_value[23:0], rx_byte}; // [R2]
            endcase
            // slot index goes out early so stored data is ready at execution
            if (byte_idx == `MCI_IDX_VAL0)
            begin
              stored_point_target_type_rd_idx <= rx_byte;
            end
            csum <= csum + rx_byte; // [R19]
            if (byte_idx == `MCI_IDX_CSUM)
            begin
              byte_idx <= 4'h0;
              csum     <= `MCI_RST_BYTE;
              if (frm_addr == `MCI_MODULE_ADDR)
              begin
                rx_ready <= 1'b0;
                state    <= S_EXEC;
              end
            end
            else
            begin
              byte_idx <= byte_idx + 4'h1;
            end
          end
        end
        S_EXEC:
        begin
          state        <= S_REPLY;
          reply_status <= `MCI_ST_OK; // [R10]
          reply_value  <= `MCI_RST_WORD;
          if (!frm_csum_ok)
          begin
            reply_status <= `MCI_ST_BAD_CSUM; // [R19]
          end
          else
          begin
            case (frm_instr)
              `MCI_MOVE_TO_POS: // [R1] [R6]
              begin
                if (frm_type == `MCI_TYPE_ABSOLUTE || frm_type == `MCI_TYPE_RELATIVE
                    || frm_type == `MCI_TYPE_STORED)
                begin
                  // 32-bit wrapping sum; overflow is the host's concern [R3] [R4]
                  if (frm_type == `MCI_TYPE_RELATIVE)
                    pw_data <= actual_pos + frm_value;
                  else if (frm_type == `MCI_TYPE_STORED)
                    pw_data <= stored_point_target_type_rd_data; // [R9]
                  else
                    pw_data <= frm_value;
                  if (frm_type == `MCI_TYPE_RELATIVE)
                    target_pos <= actual_pos + frm_value;
                  else if (frm_type == `MCI_TYPE_STORED)
                    target_pos <= stored_point_target_type_rd_data;
                  else
                    target_pos <= frm_value;
                  pw_en      <= 1'b1;
                  pw_addr    <= `MCI_AP_TARGET_POS; // [R5]
                  pos_mode   <= 1'b1; // [R5]
                  move_start <= 1'b1; // [R7]
                end
                else
                begin
                  reply_status <= `MCI_ST_BAD_TYPE;
                end
              end
              `MCI_MOTOR_STOP, `MCI_ROTATE_RIGHT, `MCI_ROTATE_LEFT:
              begin
                // velocity mode takes over any running move [R8] [R16] [R17]
                pos_mode   <= 1'b0;
                vel_update <= 1'b1;
                pw_en      <= 1'b1;
                pw_addr    <= `MCI_AP_TARGET_VEL;
                if (frm_instr == `MCI_MOTOR_STOP)
                begin
                  pw_data    <= `MCI_RST_WORD;
                  target_vel <= `MCI_RST_WORD;
                end
                else if (frm_instr == `MCI_ROTATE_LEFT)
                begin
                  pw_data    <= `MCI_RST_WORD - frm_value;
                  target_vel <= `MCI_RST_WORD - frm_value;
                end
                else
                begin
                  pw_data    <= frm_value;
                  target_vel <= frm_value;
                end
              end
              `MCI_SET_AXIS_PARAM: // [R11]
              begin
                pw_en   <= 1'b1;
                pw_addr <= frm_type;
                pw_data <= frm_value;
                if (frm_type == `MCI_AP_MAX_POS_SPD)
                begin
                  max_pos_speed <= frm_value; // [R12]
                end
                if (frm_type == `MCI_AP_TARGET_POS)
                begin
                  target_pos <= frm_value;
                end
                if (frm_type == `MCI_AP_TARGET_VEL)
                begin
                  target_vel <= frm_value;
                end
              end
              `MCI_GET_AXIS_PARAM: // [R18]
              begin
                state <= S_READ;
              end
              default:
              begin
                reply_status <= `MCI_ST_BAD_INSTR;
              end
            endcase
          end
        end
        S_READ:
        begin
          reply_value <= param_rd; // [R18]
          if (frm_standalone)
          begin
            accu <= param_rd; // [R13]
          end
          // direct mode leaves the accumulator alone [R14]
          state <= S_REPLY;
        end
        S_REPLY:
        begin
          reply_valid <= 1'b1;
          reply_addr  <= frm_addr;
          reply_instr <= frm_instr;
          rx_ready    <= 1'b1;
          state       <= S_RECV;
        end
        default:
        begin
          state    <= S_RECV;
          rx_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule

/* File: rtl/mci_map.vh */
// frame layout, instruction codes, parameter numbers and reply codes of the interpreter
`ifndef MCI_MAP_VH
`define MCI_MAP_VH

// frame geometry
`define MCI_FRAME_LEN      4'h9
`define MCI_IDX_ADDR       4'h0
`define MCI_IDX_INSTR      4'h1
`define MCI_IDX_TYPE       4'h2
`define MCI_IDX_MOTOR      4'h3
`define MCI_IDX_VAL3       4'h4
`define MCI_IDX_VAL0       4'h7
`define MCI_IDX_CSUM       4'h8

// own module address, arbitrary value
`define MCI_MODULE_ADDR    8'h01

// instruction codes
`define MCI_ROTATE_RIGHT   8'h01
`define MCI_ROTATE_LEFT    8'h02
`define MCI_MOTOR_STOP     8'h03
`define MCI_MOVE_TO_POS    8'h04
`define MCI_SET_AXIS_PARAM 8'h05
`define MCI_GET_AXIS_PARAM 8'h06

// move target types
`define MCI_TYPE_ABSOLUTE  8'h00
`define MCI_TYPE_RELATIVE  8'h01
`define MCI_TYPE_STORED    8'h02

// axis parameter numbers
`define MCI_AP_TARGET_POS  8'h00
`define MCI_AP_TARGET_VEL  8'h02
`define MCI_AP_MAX_POS_SPD 8'h04

// reply status codes
`define MCI_ST_OK          8'h64
`define MCI_ST_BAD_CSUM    8'h01
`define MCI_ST_BAD_INSTR   8'h02
`define MCI_ST_BAD_TYPE    8'h03

// reset values
`define MCI_RST_WORD       32'h0000_0000
`define MCI_RST_BYTE       8'h00

`endif

/* File: rtl/mci_param_mem.v */
// volatile axis parameter store, one write port, registered read
`timescale 1ns/100ps
module mci_param_mem
(
  input  wire        mclk,
  input  wire        wr_en,
  input  wire [7:0]  wr_addr,
  input  wire [31:0] wr_data,
  input  wire [7:0]  rd_addr,
  output reg  [31:0] rd_data
);

  reg [31:0] mem [0:255];

  always @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

/* File: dv/mci_interp_checker.sv */
// concurrent checks on the interpreter ports
`timescale 1ns/100ps
module mci_interp_checker
(
  input wire        mclk,
  input wire        rst_n,
  input wire        cmd_standalone,
  input wire        rx_ready,
  input wire        reply_valid,
  input wire [7:0]  reply_status,
  input wire [7:0]  reply_instr,
  input wire [31:0] reply_value,
  input wire [31:0] accu,
  input wire        pos_mode,
  input wire [31:0] target_pos,
  input wire        move_start,
  input wire        vel_update
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  move_mode_a: assert property (move_start |-> pos_mode)
    else $error("move launched outside position mode");
  move_reply_a: assert property (move_start |=> reply_valid && reply_status == 8'h64)
    else $error("move reply late or not ok");
  stop_mode_a: assert property (vel_update |-> !pos_mode)
    else $error("velocity load left position mode on");
  stop_reply_a: assert property (vel_update |=> reply_valid && reply_status == 8'h64)
    else $error("stop or rotate reply late or not ok");
  ready_back_a: assert property (reply_valid |-> rx_ready)
    else $error("receiver not ready at reply");
  reply_bound_a: assert property ($fell(rx_ready) |-> ##[1:4] reply_valid)
    else $error("no reply after frame");
  accu_guard_a: assert property (!$stable(accu) |-> cmd_standalone)
    else $error("accumulator changed in direct mode");
  csum_reject_a: assert property (reply_valid && reply_status == 8'h01 |->
    target_pos == $past(target_pos, 2) && pos_mode == $past(pos_mode, 2))
    else $error("bad checksum frame executed");
  value_zero_a: assert property (reply_valid && reply_instr != 8'h06 |-> reply_value == 0)
    else $error("reply value set for non-get");
endmodule
bind mci_interp mci_interp_checker u_chk (.mclk, .rst_n, .cmd_standalone, .rx_ready,
  .reply_valid, .reply_status, .reply_instr, .reply_value, .accu, .pos_mode, .target_pos,
  .move_start, .vel_update);

/* File: dv/mci_host_model.sv */
// host side model: frame sender and stored coordinate table
`timescale 1ns/100ps
module mci_host_model
(
  input  wire        mclk,
  input  wire        rx_ready,
  input  wire [7:0]  stored_point_target_type_rd_idx,
  output reg  [7:0]  rx_byte,
  output reg         rx_valid,
  output reg  [31:0] stored_point_target_type_rd_data
);
  reg [7:0] sum;
  integer   i;
  initial
  begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    stored_point_target_type_rd_data = 32'h0000_0000;
  end
  // every slot is loaded before use, value tracks the slot number
  always @(posedge mclk)
    stored_point_target_type_rd_data <= {8'hC5, 16'h0000, stored_point_target_type_rd_idx};
  // nine bytes, value msb first, 8-bit sum last
  task send(input [63:0] body, input bad);
  begin
    sum = 8'h00;
    for (i = 0; i < 9; i = i + 1)
    begin
      rx_byte <= (i == 8) ? sum + bad : body[63 - 8 * i -: 8];
      rx_valid <= 1'b1;
      if (i < 8) sum = sum + body[63 - 8 * i -: 8];
      // wait until the receiver is ready, then let one taking edge pass
      while (rx_ready !== 1'b1)
      begin
        @(posedge mclk);
        #1;
      end
      @(posedge mclk);
      #1;
    end
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  end
  endtask
endmodule

/* File: dv/mci_interp_tb.sv */
// self-checking bench for the command frame interpreter
`timescale 1ns/100ps
`include "mci_map.vh"
module mci_interp_tb;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg         cmd_standalone = 1'b0;
  reg  [31:0] actual_pos = 32'h0000_0000;
  wire [7:0]  rx_byte, reply_addr, reply_status, reply_instr, stored_point_target_type_rd_idx;
  wire [31:0] stored_point_target_type_rd_data, reply_value, accu, target_pos, target_vel, max_pos_speed;
  wire        rx_valid, rx_ready, reply_valid, pos_mode, move_start, vel_update;
  reg  [31:0] par [0:255];
  reg  [31:0] m_accu;
  reg         m_mode;
  integer     err_total, checks, s;
  always #4 mclk = ~mclk;
  mci_interp DUT (.mclk, .rst_n, .rx_byte, .rx_valid, .cmd_standalone, .actual_pos,
    .stored_point_target_type_rd_data, .rx_ready, .reply_valid, .reply_addr, .reply_status, .reply_instr,
    .reply_value, .accu, .stored_point_target_type_rd_idx, .pos_mode, .target_pos, .target_vel,
    .max_pos_speed, .move_start, .vel_update);
  mci_host_model host (.mclk, .rx_ready, .stored_point_target_type_rd_idx, .rx_byte, .rx_valid, .stored_point_target_type_rd_data);
  task finish_test;
  begin
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  // ---------------------------------------------------------------
  // reference model, one frame sent and its reply compared
  // ---------------------------------------------------------------
  task run(input [7:0] ins, input [7:0] typ, input [31:0] val, input bad);
    reg [7:0]  st;
    reg [31:0] rv;
    integer    n;
  begin
    st = `MCI_ST_OK;
    rv = 32'h0000_0000;
    if (bad) st = `MCI_ST_BAD_CSUM;
    else if (ins == 8'h00 || ins > 8'h06) st = `MCI_ST_BAD_INSTR;
    else if (ins == `MCI_MOVE_TO_POS && typ > 8'h02) st = `MCI_ST_BAD_TYPE;
    else if (ins == `MCI_MOVE_TO_POS)
    begin
      m_mode = 1'b1;
      par[0] = (typ == 8'h00) ? val : (typ == 8'h01) ? actual_pos + val
             : {8'hC5, 16'h0000, val[7:0]};
    end
    else if (ins == `MCI_SET_AXIS_PARAM) par[typ] = val;
    else if (ins == `MCI_GET_AXIS_PARAM)
    begin
      rv = par[typ];
      if (cmd_standalone) m_accu = rv;
    end
    else
    begin
      m_mode = 1'b0;
      par[2] = (ins == `MCI_MOTOR_STOP) ? 32'h0000_0000 : (ins == 8'h01) ? val : -val;
    end
    host.send({`MCI_MODULE_ADDR, ins, typ, 8'h00, val}, bad);
    for (n = 0; n < 8 && reply_valid !== 1'b1; n = n + 1) @(posedge mclk) #1;
    chk(n < 8, 1);
    chk(reply_status, st);
    chk(reply_instr, ins);
    chk(reply_addr, `MCI_MODULE_ADDR);
    chk(stored_point_target_type_rd_idx, val[7:0]);
    chk(reply_value, rv);
    chk(accu, m_accu);
    chk(pos_mode, m_mode);
    chk(target_pos, par[0]);
    chk(target_vel, par[2]);
    chk(max_pos_speed, par[4]);
  end
  endtask
  initial
  begin
    #20000;
    err_total = err_total + 1;
    finish_test;
  end
  initial
  begin
    par[0] = 32'h0000_0000;
    par[2] = 32'h0000_0000;
    par[4] = 32'h0000_0000;
    m_accu = 32'h0000_0000;
    m_mode = 1'b0;
    err_total = 0;
    checks = 0;
    s = $urandom(50);
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    run(8'h04, 8'h00, 32'h0001_5F90, 1'b0);
    run(8'h04, 8'h00, $urandom, 1'b0);
    actual_pos = $urandom;
    run(8'h04, 8'h01, 32'hFFFF_D8F0, 1'b0);
    actual_pos = 32'h7FFF_FFF0;
    run(8'h04, 8'h01, 32'h0000_0020, 1'b0);
    run(8'h04, 8'h02, 32'h0000_0008, 1'b0);
    run(8'h04, 8'h03, 32'h0000_0010, 1'b0);
    run(8'h05, 8'h04, 32'h0000_03E8, 1'b0);
    run(8'h05, 8'h10, $urandom, 1'b0);
    run(8'h06, 8'h10, 32'h0000_0000, 1'b0);
    cmd_standalone = 1'b1;
    run(8'h06, 8'h04, 32'h0000_0000, 1'b0);
    cmd_standalone = 1'b0;
    run(8'h04, 8'h00, $urandom, 1'b0);
    run(8'h03, 8'h00, 32'h0000_0000, 1'b0);
    run(8'h01, 8'h00, $urandom, 1'b0);
    run(8'h04, 8'h00, $urandom, 1'b0);
    run(8'h02, 8'h00, $urandom, 1'b0);
    run(8'h04, 8'h00, $urandom, 1'b1);
    run(8'h07, 8'h00, $urandom, 1'b0);
    // frame for another address: no reply, nothing executed
    host.send({8'h02, 8'h05, 8'h04, 8'h00, 32'h0000_1111}, 1'b0);
    repeat (4)
    begin
      @(posedge mclk) #1;
      chk(reply_valid, 1'b0);
    end
    chk(rx_ready, 1'b1);
    chk(max_pos_speed, par[4]);
    finish_test;
  end
endmodule
